// File: rtl/mcpwm_duty_mem.v
`timescale 1ns/1ps
// ****************************************
// per-channel duty store with registered read port
// ****************************************
module mcpwm_duty_mem (
    input  wire        i_clk,
    input  wire        i_reset,
    input  wire        i_load,
    input  wire [35:0] i_mask,
    input  wire [7:0]  i_value,
    input  wire [5:0]  i_raddr,
    output reg  [7:0]  o_rdata,
    output wire [287:0] o_flat
);
    reg [7:0] duty_r [0:35];
    genvar g;
    generate
        for (g = 0; g < 36; g = g + 1) begin : g_ch
            always @(posedge i_clk or posedge i_reset) begin
                if (i_reset) begin
                    duty_r[g] <= 8'h00;
                end else if (i_load && i_mask[g]) begin
                    duty_r[g] <= i_value;
                end
            end
            assign o_flat[g*8 +: 8] = duty_r[g];
        end
    endgenerate
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else if (i_raddr < 6'd36) begin
            o_rdata <= duty_r[i_raddr];
        end else begin
            o_rdata <= 8'h00;
        end
    end
endmodule // mcpwm_duty_mem

// File: rtl/mcpwm_regs.vh
`ifndef MCPWM_REGS_VH
`define MCPWM_REGS_VH
// ****************************************
// register offsets
// ****************************************
`define MCPWM_OFF_CTRL      12'h000
`define MCPWM_OFF_TOP       12'h004
`define MCPWM_OFF_DUTY      12'h008
`define MCPWM_OFF_STATUS    12'h00C
`define MCPWM_OFF_SEL0      12'h030
`define MCPWM_OFF_SEL1      12'h040
`define MCPWM_OFF_CHDUTY    12'h100
// ****************************************
// fields and reset values
// ****************************************
`define MCPWM_CTRL_EN_BIT   0
`define MCPWM_CTRL_RST      32'h0000_0000
`define MCPWM_TOP_RST       8'hFF
`define MCPWM_DUTY_RST      8'h00
`define MCPWM_NUM_CH        36
`define MCPWM_CW            8
`define MCPWM_SYNC_CYC      2'd2
`endif

// File: rtl/mcpwm_top.v
`timescale 1ns/1ps
// Contract
// - software sets enable bit of control register, after generic clock runs.
// - enabled timebase starts at zero and counts up to effective top.
// - effective top comes from software top field in generic clock cycles.
// - one timebase counter shared by every channel.
// - each channel has own duty register and comparator.
// - when clocks stop in sleep, block halts and resumes after.
// - block runs normally while cpu sits in debug mode.
// - each set select bit loads that channel from shared duty value.
// - first select covers channels 0-31, second covers 32-35.
// - writing a select register starts synchronisation at once.
// - duty changes only after synchronisation and counter at top.
// - bus interface clock active out of reset.
// - thirty-six channels, each with its own output.
`include "mcpwm_regs.vh"
module mcpwm_top (
    input  wire        I_CLK,
    input  wire        I_RESET,
    input  wire        I_PSEL,
    input  wire        I_PENABLE,
    input  wire        I_PWRITE,
    input  wire [11:0] I_PADDR,
    input  wire [31:0] I_PWDATA,
    output reg  [31:0] O_PRDATA,
    output reg         O_PREADY,
    output reg         O_PSLVERR,
    output reg  [35:0] O_PWM
);
    // ****************************************
    // apb decode
    // ****************************************
    // one wait state: ready rises the cycle after access starts,
    // which gives the duty store time to present its registered read data
    wire        acc      = I_PSEL & I_PENABLE & ~O_PREADY;
    wire        wr       = acc & I_PWRITE;
    wire        rd       = acc & ~I_PWRITE;
    wire        hit_ctrl = (I_PADDR == `MCPWM_OFF_CTRL);
    wire        hit_top  = (I_PADDR == `MCPWM_OFF_TOP);
    wire        hit_duty = (I_PADDR == `MCPWM_OFF_DUTY);
    wire        hit_stat = (I_PADDR == `MCPWM_OFF_STATUS);
    wire        hit_sel0 = (I_PADDR == `MCPWM_OFF_SEL0);
    wire        hit_sel1 = (I_PADDR == `MCPWM_OFF_SEL1);
    wire        hit_chd  = (I_PADDR[11:8] == 4'h1) && (I_PADDR[7:2] < 6'd36)
                           && (I_PADDR[1:0] == 2'b00);
    // anything off the map answers with an error and has no effect
    wire        hit_any  = hit_ctrl | hit_top | hit_duty | hit_stat
                           | hit_sel0 | hit_sel1 | hit_chd;

    reg         en_r;
    reg  [7:0]  top_r;
    reg  [7:0]  ishared_r;
    reg  [7:0]  cnt_r;
    reg  [7:0]  cnt_nxt;
    // one-hot states of the interlinked update
    localparam [2:0] UPD_IDLE = 3'b001;
    localparam [2:0] UPD_SYNC = 3'b010;
    localparam [2:0] UPD_WAIT = 3'b100;

    reg         en_nxt;
    reg  [7:0]  top_nxt;
    reg  [7:0]  ishared_nxt;
    reg  [35:0] pend_mask_r;
    reg  [35:0] pend_mask_nxt;
    reg  [7:0]  pend_val_r;
    reg  [7:0]  pend_val_nxt;
    reg  [1:0]  sync_cnt_r;
    reg  [1:0]  sync_cnt_nxt;
    reg  [2:0]  upd_state_r;
    reg  [2:0]  upd_state_nxt;
    reg  [35:0] sel_mask;
    reg  [31:0] prdata_nxt;
    reg         pready_nxt;
    reg         pslverr_nxt;
    wire        pend;
    wire [7:0]  mem_rdata;
    wire [287:0] duty_flat;

    // ****************************************
    // control registers
    // ****************************************
    // writes to status or channel duty words are ignored
    always @* begin
        en_nxt      = en_r;
        top_nxt     = top_r;
        ishared_nxt = ishared_r;
        if (wr && hit_ctrl) begin
            en_nxt = I_PWDATA[`MCPWM_CTRL_EN_BIT];
        end
        if (wr && hit_top) begin
            top_nxt = I_PWDATA[7:0];
        end
        if (wr && hit_duty) begin
            ishared_nxt = I_PWDATA[7:0];
        end
    end

    // ****************************************
    // control flops
    // ****************************************
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            en_r      <= 1'b0;
            top_r     <= `MCPWM_TOP_RST;
            ishared_r <= `MCPWM_DUTY_RST;
        end else begin
            en_r      <= en_nxt;
            top_r     <= top_nxt;
            ishared_r <= ishared_nxt;
        end
    end

    // ****************************************
    // shared timebase
    // ****************************************
    // no debug halt input exists: counting never pauses for debug
    // top lowered below the count wraps at once instead of running to 255
    wire at_top = (cnt_r >= top_r);
    always @* begin
        if (!en_r) begin
            cnt_nxt = 8'h00;
        end else if (at_top) begin
            cnt_nxt = 8'h00;
        end else begin
            cnt_nxt = cnt_r + 8'h01;
        end
    end
    // ****************************************
    // timebase flop
    // ****************************************
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // ****************************************
    // interlinked update
    // ****************************************
    // a new select write merges into the pending mask; the value is
    // the shared duty at the latest write, and sync restarts
    wire sel_wr = wr & (hit_sel0 | hit_sel1);
    always @* begin
        sel_mask = 36'h0_0000_0000;
        if (hit_sel0) begin
            sel_mask[31:0] = I_PWDATA;
        end else if (hit_sel1) begin
            // only channels 32 to 35 exist, upper select bits are dropped
            sel_mask[35:32] = I_PWDATA[3:0];
        end
    end

    // ****************************************
    // update sequencer
    // ****************************************
    // set wins: a select write in the commit cycle keeps its new bits
    wire synced = upd_state_r[2];
    wire commit = synced && en_r && at_top;
    assign pend = ~upd_state_r[0];
    always @* begin
        upd_state_nxt = upd_state_r;
        sync_cnt_nxt  = sync_cnt_r;
        pend_mask_nxt = pend_mask_r;
        pend_val_nxt  = pend_val_r;
        case (upd_state_r)
            UPD_IDLE: begin
                sync_cnt_nxt = 2'd0;
            end
            UPD_SYNC: begin
                // shared value settles before it may reach any channel
                if (sync_cnt_r <= 2'd1) begin
                    sync_cnt_nxt  = 2'd0;
                    upd_state_nxt = UPD_WAIT;
                end else begin
                    sync_cnt_nxt = sync_cnt_r - 2'd1;
                end
            end
            UPD_WAIT: begin
                // held while disabled: a mid-period load would glitch
                if (commit) begin
                    upd_state_nxt = UPD_IDLE;
                    pend_mask_nxt = 36'h0_0000_0000;
                end
            end
            default: begin
                upd_state_nxt = UPD_IDLE;
                sync_cnt_nxt  = 2'd0;
                pend_mask_nxt = 36'h0_0000_0000;
            end
        endcase
        if (sel_wr) begin
            upd_state_nxt = UPD_SYNC;
            sync_cnt_nxt  = `MCPWM_SYNC_CYC;
            pend_mask_nxt = (commit ? 36'h0_0000_0000 : pend_mask_r) | sel_mask;
            pend_val_nxt  = ishared_r;
        end
    end

    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            upd_state_r <= UPD_IDLE;
            sync_cnt_r  <= 2'd0;
            pend_mask_r <= 36'h0_0000_0000;
            pend_val_r  <= 8'h00;
        end else begin
            upd_state_r <= upd_state_nxt;
            sync_cnt_r  <= sync_cnt_nxt;
            pend_mask_r <= pend_mask_nxt;
            pend_val_r  <= pend_val_nxt;
        end
    end

    // ****************************************
    // channel duty store
    // ****************************************
    mcpwm_duty_mem u_mem (
        .i_clk   (I_CLK),
        .i_reset (I_RESET),
        .i_load  (commit),
        .i_mask  (pend_mask_r),
        .i_value (pend_val_r),
        .i_raddr (I_PADDR[7:2]),
        .o_rdata (mem_rdata),
        .o_flat  (duty_flat)
    );

    // ****************************************
    // comparators
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < `MCPWM_NUM_CH; g = g + 1) begin : g_cmp
            // a channel loaded this cycle compares against its new duty,
            // so the fresh value governs the whole next period
            wire [7:0] duty_now = (commit && pend_mask_r[g]) ? pend_val_r
                                  : duty_flat[g*8 +: 8];
            // duty 0 keeps a channel low, duty above top keeps it high
            always @(posedge I_CLK or posedge I_RESET) begin
                if (I_RESET) begin
                    O_PWM[g] <= 1'b0;
                end else begin
                    O_PWM[g] <= en_r && (cnt_nxt < duty_now);
                end
            end
        end
    endgenerate

    // ****************************************
    // apb answer
    // ****************************************
    always @* begin
        pready_nxt  = acc;
        pslverr_nxt = acc & ~hit_any;
        prdata_nxt  = 32'h0000_0000;
        if (rd) begin
            if (hit_ctrl) begin
                prdata_nxt = {31'h0000_0000, en_r};
            end else if (hit_top) begin
                prdata_nxt = {24'h00_0000, top_r};
            end else if (hit_duty) begin
                prdata_nxt = {24'h00_0000, ishared_r};
            end else if (hit_stat) begin
                prdata_nxt = {15'h0000, pend, cnt_r, 8'h00};
            end else if (hit_chd) begin
                prdata_nxt = {24'h00_0000, mem_rdata};
            end else begin
                // select registers and holes read as zero
                prdata_nxt = 32'h0000_0000;
            end
        end
    end

    // ****************************************
    // apb answer flops
    // ****************************************
    // ready pulses for one cycle; data is zero outside that pulse
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_PREADY  <= 1'b0;
            O_PSLVERR <= 1'b0;
            O_PRDATA  <= 32'h0000_0000;
        end else begin
            O_PREADY  <= pready_nxt;
            O_PSLVERR <= pslverr_nxt;
            O_PRDATA  <= prdata_nxt;
        end
    end
endmodule // mcpwm_top

// File: tb/mcpwm_chk.sv
`timescale 1ns/1ps
// ************
// port checks
// ************
module mcpwm_chk (
    input wire        I_CLK,
    input wire        I_RESET,
    input wire        I_PSEL,
    input wire        I_PENABLE,
    input wire        I_PWRITE,
    input wire [11:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    input wire [31:0] O_PRDATA,
    input wire        O_PREADY,
    input wire        O_PSLVERR,
    input wire [35:0] O_PWM
);
    reg        en_r;
    reg [35:0] seen_r;
    wire       wr = O_PREADY && I_PWRITE && !O_PSLVERR;
    // shadows lag the design by one edge, so they never run ahead of it
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            en_r <= 1'b0;
            seen_r <= 36'h0_0000_0000;
        end else if (wr) begin
            if (I_PADDR == 12'h000) en_r <= I_PWDATA[0];
            if (I_PADDR == 12'h030) seen_r[31:0] <= seen_r[31:0] | I_PWDATA;
            if (I_PADDR == 12'h040) seen_r[35:32] <= seen_r[35:32] | I_PWDATA[3:0];
        end
    end
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    chk_ready_wait: assert property (I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY)
        else $error("no ready");
    chk_ready_pulse: assert property (O_PREADY |=> !O_PREADY) else $error("ready held");
    chk_err_zero: assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h0)
        else $error("bad error reply");
    chk_idle_zero: assert property (!O_PREADY |-> O_PRDATA == 32'h0) else $error("idle");
    chk_sel_zero: assert property (O_PREADY && !I_PWRITE && I_PADDR inside {12'h030, 12'h040}
        |-> O_PRDATA == 32'h0) else $error("select read");
    chk_off_low: assert property (!en_r && !$past(en_r) |-> O_PWM == 36'h0) else $error("off");
    chk_unsel_low: assert property ((O_PWM & ~seen_r) == 36'h0) else $error("unselected");
    chk_rise_wrap: assert property (|(O_PWM & ~$past(O_PWM)) |->
        !(|($past(O_PWM) & ~O_PWM))) else $error("edge mix");
    cover property (O_PSLVERR);
    cover property (|O_PWM[35:32]);
    cover property ($fell(en_r));
endmodule // mcpwm_chk
bind mcpwm_top mcpwm_chk i_mcpwm_chk (.I_CLK, .I_RESET, .I_PSEL, .I_PENABLE, .I_PWRITE,
    .I_PADDR, .I_PWDATA, .O_PRDATA, .O_PREADY, .O_PSLVERR, .O_PWM);

// File: tb/mcpwm_load.sv
`timescale 1ns/1ps
// ************
// pin load
// ************
module mcpwm_load (
    input  wire        i_clk,
    input  wire        i_clr,
    input  wire [5:0]  i_ch,
    input  wire [35:0] i_pwm,
    output reg  [15:0] o_high
);
    // one watched pin is enough, unused outputs stay unloaded
    always @(posedge i_clk) begin
        if (i_clr) o_high <= 16'h0000;
        else if (i_pwm[i_ch]) o_high <= o_high + 16'h0001;
    end
endmodule // mcpwm_load

// File: tb/mcpwm_top_tb.sv
`timescale 1ns/1ps
module mcpwm_top_tb;
    logic        I_CLK = 0, I_RESET = 1, I_PSEL = 0, I_PENABLE = 0, I_PWRITE = 0, clr = 1;
    logic [11:0] I_PADDR = 0;
    logic [31:0] I_PWDATA = 0;
    logic [33:0] n, q[$];
    logic [5:0]  ch = 0;
    wire  [31:0] O_PRDATA;
    wire  [35:0] O_PWM;
    wire  [15:0] high;
    wire         O_PREADY, O_PSLVERR;
    int          fail_count = 0, checks_done = 0, cyc = 0, c, d;
    mcpwm_top i_mcpwm_top (.I_CLK, .I_RESET, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR,
        .I_PWDATA, .O_PRDATA, .O_PREADY, .O_PSLVERR, .O_PWM);
    mcpwm_load i_mcpwm_load (.i_clk(I_CLK), .i_clr(clr), .i_ch(ch), .i_pwm(O_PWM), .o_high(high));
    initial forever #2.5 I_CLK = ~I_CLK;
    task cmp(input string s, input logic [35:0] e, g);
        checks_done++;
        if (g !== e) fail_count++;
        if (g !== e) $display("mismatch %s expected %h seen %h", s, e, g);
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // note: [33] compare data, [32] error expected, [31:0] data
    task apb(input logic w, input logic [11:0] a, input logic [31:0] v, input logic [33:0] e);
        @(posedge I_CLK) q.push_back(e);
        I_PSEL <= 1'b1;
        I_PWRITE <= w;
        I_PADDR <= a;
        I_PWDATA <= v;
        @(posedge I_CLK) I_PENABLE <= 1'b1;
        do @(posedge I_CLK); while (O_PREADY !== 1'b1);
        I_PSEL <= 1'b0;
        I_PENABLE <= 1'b0;
    endtask
    always @(posedge I_CLK) begin
        cyc++;
        if (O_PREADY === 1'b1) n = q.pop_front();
        if (O_PREADY === 1'b1) cmp("slverr", n[32], O_PSLVERR);
        if (O_PREADY === 1'b1 && n[33]) cmp("prdata", n[31:0], O_PRDATA);
        if (cyc == 5000) begin
            fail_count++;
            end_of_test;
        end
    end
    // whole periods in the window, so the phase does not matter
    task count(input int e);
        @(posedge I_CLK) clr <= 1'b1;
        @(posedge I_CLK) clr <= 1'b0;
        repeat (50) @(posedge I_CLK);
        @(negedge I_CLK) cmp("high", e, high);
    endtask
    initial begin
        // no interrupt lines here, so nothing to program first
        c = $urandom(32'h6fa9);
        repeat (10) @(posedge I_CLK);
        I_RESET <= 1'b0;
        apb(0, 12'h004, 0, 34'h2_0000_00FF);
        apb(0, 12'h030, 0, 34'h2_0000_0000);
        apb(0, 12'h0F0, 0, 34'h3_0000_0000);
        apb(1, 12'h004, 9, 0);
        apb(1, 12'h000, 1, 0);
        for (int i = 0; i < 5; i++) begin
            c = $urandom % 36;
            d = 1 + $urandom % 12;
            ch <= c[5:0];
            apb(1, 12'h008, d, 0);
            apb(1, c < 32 ? 12'h030 : 12'h040, 32'h1 << (c % 32), 0);
            repeat (15) @(posedge I_CLK);
            apb(0, 12'(12'h100 + 4 * c), 0, {2'b10, 24'h00_0000, d[7:0]});
            count(d > 10 ? 50 : 5 * d);
        end
        apb(1, 12'h000, 0, 0);
        apb(0, 12'h00C, 0, 34'h2_0000_0000);
        count(0);
        end_of_test;
    end
endmodule // mcpwm_top_tb
